// file: crf_gpr_if.sv
// Carrier between the register file top and its general-purpose register memory.
`timescale 1ns/1ps
`default_nettype none
interface crf_gpr_if;
  logic wr_en;
  logic [4:0] wr_idx;
  logic [31:0] wr_data;
  logic [4:0] rd_a_idx;
  logic [4:0] rd_b_idx;
  logic [31:0] rd_a_data;
  logic [31:0] rd_b_data;
  logic [31:0] rd_base_data;
  modport ctrl (output wr_en, wr_idx, wr_data, rd_a_idx, rd_b_idx,
                input rd_a_data, rd_b_data, rd_base_data);
  modport mem (input wr_en, wr_idx, wr_data, rd_a_idx, rd_b_idx,
               output rd_a_data, rd_b_data, rd_base_data);
endinterface : crf_gpr_if
`default_nettype wire

// file: crf_gpr_mem.sv
// General-purpose register memory with registered read ports.
`timescale 1ns/1ps
`default_nettype none
module crf_gpr_mem (
  input wire logic ref_clk,
  input wire logic rstn,
  crf_gpr_if.mem bus
);
  logic [31:0] mem_r [crf_pkg::GPR_COUNT];

  // Storage; writes to the zero register are dropped so it never holds a value.
  // discard zero writes
  genvar g;
  generate
    for (g = 0; g < crf_pkg::GPR_COUNT; g++) begin : g_word
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          mem_r[g] <= crf_pkg::RESET_WORD;
        end else if (bus.wr_en && bus.wr_idx == 5'(g) && g != 0) begin
          mem_r[g] <= bus.wr_data;
        end
      end
    end
  endgenerate

  // Registered reads; index zero always returns zero.
  // zero register reads
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus.rd_a_data <= crf_pkg::RESET_WORD;
      bus.rd_b_data <= crf_pkg::RESET_WORD;
      bus.rd_base_data <= crf_pkg::RESET_WORD;
    end else begin
      bus.rd_a_data <= (bus.rd_a_idx == crf_pkg::GPR_ZERO) ? crf_pkg::RESET_WORD
                                                           : mem_r[bus.rd_a_idx];
      bus.rd_b_data <= (bus.rd_b_idx == crf_pkg::GPR_ZERO) ? crf_pkg::RESET_WORD
                                                           : mem_r[bus.rd_b_idx];
      bus.rd_base_data <= mem_r[crf_pkg::GPR_ELEMENT_BASE];
    end
  end

  // Zero register must read as zero one cycle after it is addressed.
  chk_zero_reads: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd_a_idx == crf_pkg::GPR_ZERO |=> bus.rd_a_data == crf_pkg::RESET_WORD)
    else $error("zero register read nonzero");
endmodule : crf_gpr_mem
`default_nettype wire

// file: crf_pipe_model.sv
// Pipeline-side model that issues system register load and store instructions.
`timescale 1ns/1ps
`default_nettype none
module crf_pipe_model (
  input wire logic ref_clk,
  output logic sysreg_load_insn,
  output logic sysreg_store_insn,
  output logic [4:0] sysreg_num,
  output logic [31:0] sysreg_wr_data
);
  // Start idle, with no instruction in flight.
  initial begin
    sysreg_load_insn = 1'b0;
    sysreg_store_insn = 1'b0;
    sysreg_num = 5'h00;
    sysreg_wr_data = 32'h0000_0000;
  end
  task automatic issue(input logic ld, input logic [4:0] num, input logic [31:0] d);
    @(negedge ref_clk);
    sysreg_load_insn = ld;
    sysreg_store_insn = !ld;
    sysreg_num = num;
    sysreg_wr_data = d;
    @(negedge ref_clk);
    sysreg_load_insn = 1'b0;
    sysreg_store_insn = 1'b0;
    sysreg_wr_data = ~d; // Stale operand is inverted so it is never trusted.
  endtask : issue
endmodule : crf_pipe_model
`default_nettype wire

// file: crf_pkg.sv
// Shared constants and types of the core register file block.
package crf_pkg;
  localparam int unsigned XLEN = 32;
  localparam int unsigned GPR_COUNT = 32;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned PC_TOP = 25;
  localparam int unsigned STAT_TOP = 7;
  localparam logic [4:0] GPR_ZERO = 5'h00;
  localparam logic [4:0] GPR_ELEMENT_BASE = 5'h1e;
  localparam logic [4:0] SR_IRQ_SAVED_PC = 5'h00;
  localparam logic [4:0] SR_IRQ_SAVED_STATUS = 5'h01;
  localparam logic [4:0] SR_NMI_SAVED_PC = 5'h02;
  localparam logic [4:0] SR_NMI_SAVED_STATUS = 5'h03;
  localparam logic [4:0] SR_EXCEPTION_SOURCE = 5'h04;
  localparam logic [4:0] SR_PROGRAM_STATUS_WORD = 5'h05;
  localparam logic [4:0] SR_TABLE_CALL_SAVED_PC = 5'h10;
  localparam logic [4:0] SR_TABLE_CALL_SAVED_STATUS = 5'h11;
  localparam logic [4:0] SR_DEBUG_SAVED_PC = 5'h12;
  localparam logic [4:0] SR_DEBUG_SAVED_STATUS = 5'h13;
  localparam logic [4:0] SR_TABLE_CALL_BASE = 5'h14;
  localparam int unsigned NMI_FLAG_BIT = 7;
  localparam logic [31:0] PC_MASK = 32'h03ff_fffe;
  localparam logic [31:0] STAT_MASK = 32'h0000_00ff;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [31:0] NMI_FLAG = 32'h0000_0080;
  typedef enum logic [1:0] {CRF_MODE_RUN, CRF_MODE_IRQ, CRF_MODE_NMI, CRF_MODE_DEBUG} crf_mode_t;
endpackage : crf_pkg

// file: crf_top.sv
// Core register file: general registers, program counter and system registers.
`timescale 1ns/1ps
`default_nettype none
module crf_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic gpr_wr_en,
  input wire logic [4:0] gpr_wr_idx,
  input wire logic [31:0] gpr_wr_data,
  input wire logic [4:0] gpr_rd_a_idx,
  input wire logic [4:0] gpr_rd_b_idx,
  output logic [31:0] gpr_rd_a_data,
  output logic [31:0] gpr_rd_b_data,
  output logic [31:0] element_base_data,
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_addr,
  input wire logic [31:0] next_insn_addr,
  input wire logic status_wr_en,
  input wire logic [31:0] status_wr_data,
  input wire logic sysreg_load_insn,
  input wire logic sysreg_store_insn,
  input wire logic [4:0] sysreg_num,
  input wire logic [31:0] sysreg_wr_data,
  output logic [31:0] sysreg_rd_data,
  output logic sysreg_access_err,
  input wire logic irq_take,
  input wire logic nmi_take,
  input wire logic [31:0] exc_code,
  input wire logic interrupt_return_insn,
  input wire logic table_call_insn,
  input wire logic debug_trap_insn,
  input wire logic illegal_opcode,
  input wire logic debug_return_insn,
  output logic [31:0] instruction_pointer,
  output logic [31:0] program_status_word,
  output logic [31:0] table_call_base,
  output logic debug_window
);
  crf_gpr_if gif ();
  logic [31:0] pc_r;
  logic [31:0] pc_nxt;
  logic [31:0] psw_r;
  logic [31:0] irq_saved_pc_r;
  logic [31:0] irq_saved_status_r;
  logic [31:0] nmi_saved_pc_r;
  logic [31:0] nmi_saved_status_r;
  logic [31:0] exception_source_r;
  logic [31:0] table_call_saved_pc_r;
  logic [31:0] table_call_saved_status_r;
  logic [31:0] debug_saved_pc_r;
  logic [31:0] debug_saved_status_r;
  logic [31:0] table_call_base_r;
  logic [31:0] rd_mux;
  logic ld_ok;
  logic dbg_ok;
  crf_pkg::crf_mode_t mode_r;
  logic rd_err;
  logic ld_err;
  // Decode a system register number: one when it names a real register.
  // number decode
  function automatic logic sr_mapped(input logic [4:0] n);
    sr_mapped = (n <= crf_pkg::SR_PROGRAM_STATUS_WORD) ||
                (n >= crf_pkg::SR_TABLE_CALL_SAVED_PC && n <= crf_pkg::SR_TABLE_CALL_BASE);
  endfunction : sr_mapped
  // One when the number is the debug save pair.
  function automatic logic sr_is_debug(input logic [4:0] n);
    sr_is_debug = (n == crf_pkg::SR_DEBUG_SAVED_PC) || (n == crf_pkg::SR_DEBUG_SAVED_STATUS);
  endfunction : sr_is_debug
  // General register memory; the top only forwards indexes and write data.
  // thirty-two registers
  assign gif.wr_en = gpr_wr_en;
  assign gif.wr_idx = gpr_wr_idx;
  assign gif.wr_data = gpr_wr_data;
  assign gif.rd_a_idx = gpr_rd_a_idx;
  assign gif.rd_b_idx = gpr_rd_b_idx;
  crf_gpr_mem u_gpr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bus(gif.mem)
  );

  // Memory read ports are already registered, so outputs come from flip-flops.
  assign gpr_rd_a_data = gif.rd_a_data;
  assign gpr_rd_b_data = gif.rd_b_data;
  assign element_base_data = gif.rd_base_data;
  // Debug pair access window, and sysreg load legality for the addressed number.
  // debug window gate
  assign dbg_ok = (mode_r == crf_pkg::CRF_MODE_DEBUG);
  assign ld_ok = sysreg_load_insn && sr_mapped(sysreg_num) &&
                 (sysreg_num != crf_pkg::SR_EXCEPTION_SOURCE) &&
                 (!sr_is_debug(sysreg_num) || dbg_ok);
  assign rd_err = sysreg_store_insn &&
                  (!sr_mapped(sysreg_num) || (sr_is_debug(sysreg_num) && !dbg_ok));
  assign ld_err = sysreg_load_insn && !ld_ok;
  // Service mode tracks only the debug trap window; interrupt context lives in the status flag.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= crf_pkg::CRF_MODE_RUN;
    end else begin
      case (mode_r)
        crf_pkg::CRF_MODE_DEBUG: begin
          if (debug_return_insn) begin
            mode_r <= crf_pkg::CRF_MODE_RUN;
          end
        end
        default: begin
          if (debug_trap_insn || illegal_opcode) begin
            mode_r <= crf_pkg::CRF_MODE_DEBUG;
          end
        end
      endcase
    end
  end

  // Program counter next value; return restores from the pair the flag selects.
  // return pair select
  always_comb begin
    pc_nxt = pc_r;
    if (interrupt_return_insn) begin
      pc_nxt = psw_r[crf_pkg::NMI_FLAG_BIT] ? nmi_saved_pc_r : irq_saved_pc_r;
    end else if (debug_return_insn) begin
      pc_nxt = debug_saved_pc_r;
    end else if (pc_load) begin
      pc_nxt = pc_load_addr;
    end else if (pc_advance) begin
      pc_nxt = pc_r + crf_pkg::PC_STEP;
    end
  end

  // Masking drops the carry past bit 25 and forces even addresses.
  // pc high bits zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= crf_pkg::RESET_WORD;
    end else begin
      pc_r <= pc_nxt & crf_pkg::PC_MASK;
    end
  end

  // Status word: return restores, sysreg load writes, nmi entry sets the flag.
  // reserved status bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      psw_r <= crf_pkg::RESET_WORD;
    end else if (nmi_take) begin
      psw_r <= (psw_r | crf_pkg::NMI_FLAG) & crf_pkg::STAT_MASK;
    end else if (interrupt_return_insn) begin
      psw_r <= (psw_r[crf_pkg::NMI_FLAG_BIT] ? nmi_saved_status_r : irq_saved_status_r)
               & crf_pkg::STAT_MASK;
    end else if (debug_return_insn) begin
      psw_r <= debug_saved_status_r & crf_pkg::STAT_MASK;
    end else if (ld_ok && sysreg_num == crf_pkg::SR_PROGRAM_STATUS_WORD) begin
      psw_r <= sysreg_wr_data & crf_pkg::STAT_MASK;
    end else if (status_wr_en) begin
      psw_r <= status_wr_data & crf_pkg::STAT_MASK;
    end
  end

  // Maskable pair: hardware save wins over a same-cycle sysreg load.
  // irq context save
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_saved_pc_r <= crf_pkg::RESET_WORD;
      irq_saved_status_r <= crf_pkg::RESET_WORD;
    end else if (irq_take && !nmi_take) begin
      irq_saved_pc_r <= next_insn_addr & crf_pkg::PC_MASK;
      irq_saved_status_r <= psw_r & crf_pkg::STAT_MASK;
    end else if (ld_ok) begin
      if (sysreg_num == crf_pkg::SR_IRQ_SAVED_PC) begin
        irq_saved_pc_r <= sysreg_wr_data & (crf_pkg::PC_MASK | 32'h0000_0001);
      end
      if (sysreg_num == crf_pkg::SR_IRQ_SAVED_STATUS) begin
        irq_saved_status_r <= sysreg_wr_data & crf_pkg::STAT_MASK;
      end
    end
  end

  // Non-maskable pair, taken instead of the maskable pair.
  // nmi context save
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nmi_saved_pc_r <= crf_pkg::RESET_WORD;
      nmi_saved_status_r <= crf_pkg::RESET_WORD;
    end else if (nmi_take) begin
      nmi_saved_pc_r <= next_insn_addr & crf_pkg::PC_MASK;
      nmi_saved_status_r <= psw_r & crf_pkg::STAT_MASK;
    end else if (ld_ok) begin
      if (sysreg_num == crf_pkg::SR_NMI_SAVED_PC) begin
        nmi_saved_pc_r <= sysreg_wr_data & (crf_pkg::PC_MASK | 32'h0000_0001);
      end
      if (sysreg_num == crf_pkg::SR_NMI_SAVED_STATUS) begin
        nmi_saved_status_r <= sysreg_wr_data & crf_pkg::STAT_MASK;
      end
    end
  end

  // Exception source is loaded by hardware only; sysreg load cannot reach it.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      exception_source_r <= crf_pkg::RESET_WORD;
    end else if (irq_take || nmi_take) begin
      exception_source_r <= exc_code;
    end
  end

  // Table-call pair and base; a table call saves context like an interrupt.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      table_call_saved_pc_r <= crf_pkg::RESET_WORD;
      table_call_saved_status_r <= crf_pkg::RESET_WORD;
      table_call_base_r <= crf_pkg::RESET_WORD;
    end else if (table_call_insn) begin
      table_call_saved_pc_r <= next_insn_addr & crf_pkg::PC_MASK;
      table_call_saved_status_r <= psw_r & crf_pkg::STAT_MASK;
    end else if (ld_ok) begin
      if (sysreg_num == crf_pkg::SR_TABLE_CALL_SAVED_PC) begin
        table_call_saved_pc_r <= sysreg_wr_data & (crf_pkg::PC_MASK | 32'h0000_0001);
      end
      if (sysreg_num == crf_pkg::SR_TABLE_CALL_SAVED_STATUS) begin
        table_call_saved_status_r <= sysreg_wr_data & crf_pkg::STAT_MASK;
      end
      if (sysreg_num == crf_pkg::SR_TABLE_CALL_BASE) begin
        table_call_base_r <= sysreg_wr_data;
      end
    end
  end

  // Debug pair: saved on trap entry, writable only inside the window.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      debug_saved_pc_r <= crf_pkg::RESET_WORD;
      debug_saved_status_r <= crf_pkg::RESET_WORD;
    end else if ((debug_trap_insn || illegal_opcode) && !dbg_ok) begin
      debug_saved_pc_r <= next_insn_addr & crf_pkg::PC_MASK;
      debug_saved_status_r <= psw_r & crf_pkg::STAT_MASK;
    end else if (ld_ok) begin
      if (sysreg_num == crf_pkg::SR_DEBUG_SAVED_PC) begin
        debug_saved_pc_r <= sysreg_wr_data & (crf_pkg::PC_MASK | 32'h0000_0001);
      end
      if (sysreg_num == crf_pkg::SR_DEBUG_SAVED_STATUS) begin
        debug_saved_status_r <= sysreg_wr_data & crf_pkg::STAT_MASK;
      end
    end
  end

  // Read multiplexer for the sysreg store instruction.
  // sysreg read path
  always_comb begin
    rd_mux = crf_pkg::RESET_WORD;
    case (sysreg_num)
      crf_pkg::SR_IRQ_SAVED_PC: rd_mux = irq_saved_pc_r;
      crf_pkg::SR_IRQ_SAVED_STATUS: rd_mux = irq_saved_status_r;
      crf_pkg::SR_NMI_SAVED_PC: rd_mux = nmi_saved_pc_r;
      crf_pkg::SR_NMI_SAVED_STATUS: rd_mux = nmi_saved_status_r;
      crf_pkg::SR_EXCEPTION_SOURCE: rd_mux = exception_source_r;
      crf_pkg::SR_PROGRAM_STATUS_WORD: rd_mux = psw_r;
      crf_pkg::SR_TABLE_CALL_SAVED_PC: rd_mux = table_call_saved_pc_r;
      crf_pkg::SR_TABLE_CALL_SAVED_STATUS: rd_mux = table_call_saved_status_r;
      crf_pkg::SR_DEBUG_SAVED_PC: rd_mux = dbg_ok ? debug_saved_pc_r : crf_pkg::RESET_WORD;
      crf_pkg::SR_DEBUG_SAVED_STATUS: rd_mux = dbg_ok ? debug_saved_status_r
                                                      : crf_pkg::RESET_WORD;
      crf_pkg::SR_TABLE_CALL_BASE: rd_mux = table_call_base_r;
      default: rd_mux = crf_pkg::RESET_WORD;
    endcase
  end

  // Read data is registered and held between store instructions.
  // Unmapped and out-of-window accesses read zero and flag an error for a cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sysreg_rd_data <= crf_pkg::RESET_WORD;
      sysreg_access_err <= 1'b0;
    end else begin
      if (sysreg_store_insn) begin
        sysreg_rd_data <= rd_mux;
      end
      sysreg_access_err <= rd_err || ld_err;
    end
  end

  // Architectural state outputs, registered copies.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      instruction_pointer <= crf_pkg::RESET_WORD;
      program_status_word <= crf_pkg::RESET_WORD;
      table_call_base <= crf_pkg::RESET_WORD;
      debug_window <= 1'b0;
    end else begin
      instruction_pointer <= pc_nxt & crf_pkg::PC_MASK;
      program_status_word <= psw_r;
      table_call_base <= table_call_base_r;
      debug_window <= (mode_r == crf_pkg::CRF_MODE_DEBUG);
    end
  end
  chk_pc_even_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    (pc_r & ~crf_pkg::PC_MASK) == crf_pkg::RESET_WORD)
    else $error("pc reserved bits set");
  chk_irq_save_pc: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_take && !nmi_take |=> irq_saved_pc_r == ($past(next_insn_addr) & crf_pkg::PC_MASK)
      && irq_saved_status_r == $past(psw_r))
    else $error("irq context not saved");
  chk_nmi_save_pc: assert property (@(posedge ref_clk) disable iff (!rstn)
    nmi_take |=> nmi_saved_pc_r == ($past(next_insn_addr) & crf_pkg::PC_MASK)
      && irq_saved_pc_r == $past(irq_saved_pc_r))
    else $error("nmi context not saved");
  chk_nmi_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    nmi_take |=> psw_r[crf_pkg::NMI_FLAG_BIT])
    else $error("nmi flag not set");
  chk_status_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
    (psw_r | irq_saved_status_r | nmi_saved_status_r) <= crf_pkg::STAT_MASK)
    else $error("status reserved bits set");
  chk_ecr_no_load: assert property (@(posedge ref_clk) disable iff (!rstn)
    sysreg_load_insn && sysreg_num == crf_pkg::SR_EXCEPTION_SOURCE && !irq_take && !nmi_take
      |=> $stable(exception_source_r) && sysreg_access_err)
    else $error("exception source written");
  chk_interrupt_return_insn_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
    interrupt_return_insn && !debug_return_insn |=>
      pc_r == (($past(psw_r[crf_pkg::NMI_FLAG_BIT]) ?
      $past(nmi_saved_pc_r) : $past(irq_saved_pc_r)) & crf_pkg::PC_MASK))
    else $error("wrong return pair");
  chk_debug_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    sysreg_store_insn && sr_is_debug(sysreg_num) && !dbg_ok
      |=> sysreg_rd_data == crf_pkg::RESET_WORD && sysreg_access_err)
    else $error("debug pair read outside window");
  cov_nmi: cover property (@(posedge ref_clk) disable iff (!rstn) nmi_take);
  cov_interrupt_return_insn_nmi: cover property (@(posedge ref_clk) disable iff (!rstn)
    interrupt_return_insn && psw_r[crf_pkg::NMI_FLAG_BIT]);
  cov_debug_rd: cover property (@(posedge ref_clk) disable iff (!rstn)
    sysreg_store_insn && sr_is_debug(sysreg_num) && dbg_ok);
endmodule : crf_top
`default_nettype wire

// file: crf_top_test.sv
// Self-checking bench of the core register file.
`timescale 1ns/1ps
`default_nettype none
module crf_top_test;
  logic ref_clk, rstn, gpr_wr_en, pc_advance, pc_load, status_wr_en, irq_take, nmi_take;
  logic interrupt_return_insn, table_call_insn, debug_trap_insn, illegal_opcode;
  logic debug_return_insn, sysreg_load_insn, sysreg_store_insn, sysreg_access_err, debug_window;
  logic [4:0] gpr_wr_idx, gpr_rd_a_idx, gpr_rd_b_idx, sysreg_num;
  logic [31:0] gpr_wr_data, gpr_rd_a_data, gpr_rd_b_data, element_base_data, pc_load_addr;
  logic [31:0] next_insn_addr, status_wr_data, sysreg_wr_data, sysreg_rd_data, exc_code;
  logic [31:0] instruction_pointer, program_status_word, table_call_base, a, s;
  logic [31:0] mem [32];
  logic [4:0] ok_num [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h10, 5'h11, 5'h14};
  logic [4:0] bad_num [6] = '{5'h06, 5'h0f, 5'h15, 5'h1f, 5'h12, 5'h13};
  int miscompares, total_checks;
  crf_top uut (.ref_clk, .rstn, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data, .gpr_rd_a_idx,
    .gpr_rd_b_idx, .gpr_rd_a_data, .gpr_rd_b_data, .element_base_data, .pc_advance, .pc_load,
    .pc_load_addr, .next_insn_addr, .status_wr_en, .status_wr_data, .sysreg_load_insn,
    .sysreg_store_insn, .sysreg_num, .sysreg_wr_data, .sysreg_rd_data, .sysreg_access_err,
    .irq_take, .nmi_take, .exc_code, .interrupt_return_insn, .table_call_insn,
    .debug_trap_insn, .illegal_opcode, .debug_return_insn, .instruction_pointer,
    .program_status_word, .table_call_base, .debug_window);
  crf_pipe_model pipe (.ref_clk, .sysreg_load_insn, .sysreg_store_insn, .sysreg_num,
    .sysreg_wr_data);
  // Clock of 40 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Saved PCs keep bit 0 on load; status-like registers keep only the low byte.
  function automatic logic [31:0] exp_sr(input logic [4:0] n, input logic [31:0] d);
    case (n)
      5'h00, 5'h02, 5'h10: return d & 32'h03ff_ffff;
      5'h14: return d;
      default: return d & crf_pkg::STAT_MASK;
    endcase
  endfunction : exp_sr
  // Word compare; flags are widened to a word.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle strobe; the edge between the two falling edges takes it.
  task automatic pulse(ref logic sig);
    @(negedge ref_clk);
    sig = 1'b1;
    @(negedge ref_clk);
    sig = 1'b0;
  endtask : pulse
  // Store then compare read data and error flag.
  task automatic rd(input logic [4:0] n, input logic [31:0] exp, input logic err);
    pipe.issue(1'b0, n, 32'h0000_0000);
    chk(sysreg_rd_data, exp);
    chk({31'h0, sysreg_access_err}, {31'h0, err});
  endtask : rd
  // Verdict in one place.
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // A hang costs a mismatch; the run needs well under a thousand cycles.
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
  // Main sequence.
  initial begin
    {gpr_wr_en, pc_advance, pc_load, status_wr_en, irq_take, nmi_take} = 6'h00;
    {interrupt_return_insn, table_call_insn, debug_trap_insn} = 3'h0;
    {illegal_opcode, debug_return_insn} = 2'h0;
    {gpr_wr_idx, gpr_rd_a_idx, gpr_rd_b_idx} = 15'h0000;
    {gpr_wr_data, pc_load_addr, next_insn_addr, status_wr_data, exc_code} = 160'h0;
    rstn = 1'b0;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(62187));
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(negedge ref_clk);
      gpr_wr_en = 1'b1;
      gpr_wr_idx = i[4:0];
      gpr_wr_data = $urandom();
      mem[i] = gpr_wr_data & {32{i != 0}};
    end
    @(negedge ref_clk);
    gpr_wr_en = 1'b0;
    for (int i = 0; i < 32; i++) begin
      gpr_rd_a_idx = i[4:0];
      gpr_rd_b_idx = 5'h1f - i[4:0];
      @(negedge ref_clk);
      chk(gpr_rd_a_data, mem[i]);
      chk(gpr_rd_b_data, mem[31 - i]);
    end
    chk(element_base_data, mem[30]);
    pc_load_addr = 32'hffff_ffff;
    pulse(pc_load);
    chk(instruction_pointer, 32'h03ff_fffe);
    pulse(pc_advance);
    chk(instruction_pointer, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      a = $urandom();
      pipe.issue(1'b1, ok_num[i], a);
      rd(ok_num[i], exp_sr(ok_num[i], a), 1'b0);
      if (ok_num[i] == 5'h14) chk(table_call_base, a);
    end
    for (int i = 0; i < 6; i++) begin
      pipe.issue(1'b1, bad_num[i], $urandom());
      chk({31'h0, sysreg_access_err}, 32'h0000_0001);
      rd(bad_num[i], 32'h0000_0000, 1'b1);
    end
    pipe.issue(1'b1, 5'h04, 32'hffff_ffff);
    rd(5'h04, 32'h0000_0000, 1'b0);
    pulse(illegal_opcode);
    @(negedge ref_clk);
    chk({31'h0, debug_window}, 32'h0000_0001);
    a = $urandom();
    pipe.issue(1'b1, 5'h13, a);
    chk({31'h0, sysreg_access_err}, 32'h0000_0000);
    rd(5'h13, a & crf_pkg::STAT_MASK, 1'b0);
    pulse(debug_return_insn);
    rd(5'h13, 32'h0000_0000, 1'b1);
    pipe.issue(1'b1, 5'h05, 32'h0000_0000);
    next_insn_addr = $urandom();
    exc_code = $urandom();
    pulse(irq_take);
    rd(5'h00, next_insn_addr & crf_pkg::PC_MASK, 1'b0);
    rd(5'h01, 32'h0000_0000, 1'b0);
    rd(5'h04, exc_code, 1'b0);
    s = $urandom() & 32'h0000_007f;
    pipe.issue(1'b1, 5'h05, s);
    a = $urandom();
    next_insn_addr = a;
    pulse(nmi_take);
    rd(5'h02, a & crf_pkg::PC_MASK, 1'b0);
    rd(5'h03, s, 1'b0);
    chk(program_status_word & crf_pkg::NMI_FLAG, crf_pkg::NMI_FLAG);
    pulse(interrupt_return_insn);
    chk(instruction_pointer, a & crf_pkg::PC_MASK);
    rd(5'h05, s, 1'b0);
    a = $urandom() | 32'h0000_0001;
    s = $urandom() & 32'h0000_007f;
    pipe.issue(1'b1, 5'h00, a);
    pipe.issue(1'b1, 5'h01, s);
    pulse(interrupt_return_insn);
    chk(instruction_pointer, a & crf_pkg::PC_MASK);
    rd(5'h05, s, 1'b0);
    // Table call and debug trap save context; debug return restores it and shuts the window.
    a = $urandom();
    next_insn_addr = a;
    pulse(table_call_insn);
    rd(5'h10, a & crf_pkg::PC_MASK, 1'b0);
    rd(5'h11, s, 1'b0);
    pulse(debug_trap_insn);
    rd(5'h12, a & crf_pkg::PC_MASK, 1'b0);
    pulse(debug_return_insn);
    chk(instruction_pointer, a & crf_pkg::PC_MASK);
    @(negedge ref_clk);
    chk({31'h0, debug_window}, 32'h0000_0000);
    status_wr_data = $urandom();
    pulse(status_wr_en);
    rd(5'h05, status_wr_data & crf_pkg::STAT_MASK, 1'b0);
    final_report();
  end
endmodule : crf_top_test
`default_nettype wire
